//--- pmtg_pkg.sv
`default_nettype none
package pmtg_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_SYS_CTRL_ONE = 8'h00;
    localparam logic [7:0] ADDR_SYS_CTRL_TWO = 8'h04;
    localparam logic [7:0] ADDR_TIMER_A_MODE = 8'h08;
    localparam logic [7:0] ADDR_CLK_GATE_ONE = 8'h0c;
    localparam logic [7:0] ADDR_CLK_GATE_TWO = 8'h10;
    localparam logic [7:0] ADDR_INT_ENABLE_TWO = 8'h14;
    localparam logic [7:0] ADDR_EVT_STATUS = 8'h18;
    localparam logic [7:0] ADDR_EVT_CLEAR = 8'h1c;
    localparam logic [7:0] ADDR_EVT_ENABLE = 8'h20;
    localparam logic [7:0] ADDR_MODE_STATUS = 8'h24;
    // system_control_one fields
    localparam int SC1_STANDBY_SELECT = 7;
    localparam int SC1_OSC_WAIT_HI = 6;
    localparam int SC1_OSC_WAIT_LO = 4;
    localparam int SC1_LOW_SPEED_SELECT = 3;
    // system_control_two fields
    localparam int SC2_DIRECT_TRANSFER_ENABLE = 3;
    localparam int SC2_MEDIUM_SPEED_SELECT = 2;
    // timer_a_mode_register field
    localparam int TMA_WATCH_ENTRY_SELECT = 3;
    // int enable two: direct-transfer interrupt enable
    localparam int IE2_DIRECT_TRANSFER = 0;
    // event status bits
    localparam int EVT_TRANSITION_DONE = 0;
    localparam int EVT_SLEEP_ENTERED = 1;
    localparam int EVT_WATCH_ENTERED = 2;
    localparam int EVT_WIDTH = 3;
    // reset values
    localparam logic [7:0] RST_CLK_GATE = 8'hff;
    localparam logic [7:0] RST_CTRL = 8'h00;
    // state counts
    localparam int SLEEP_EXEC_STATES = 2;
    localparam int INT_PROC_STATES = 1;
    localparam int EXC_STATES = 14;
    localparam int WATCH_PASS_STATES = 1;
    typedef enum logic [1:0] {
        PMTG_MODE_FAST = 2'b00,
        PMTG_MODE_MED = 2'b01,
        PMTG_MODE_SUB = 2'b10
    } pmtg_mode_e;
    typedef enum logic [2:0] {
        PMTG_ST_RUN = 3'b000,
        PMTG_ST_SLEEP_EXEC = 3'b001,
        PMTG_ST_INT_PROC = 3'b010,
        PMTG_ST_WATCH = 3'b011,
        PMTG_ST_OSC_WAIT = 3'b100,
        PMTG_ST_EXC = 3'b101,
        PMTG_ST_HALT = 3'b110
    } pmtg_state_e;
endpackage
`default_nettype wire

//--- pmtg_ctrl.sv
// Operation
// - sleep in fast mode, standby 0, low 0, medium 1, direct 1 goes to divided mode.
// - sleep in divided mode, standby/low/medium 0, direct 1 goes to fast mode.
// - sleep in subclock mode, standby 1, low 0, medium 0, direct 1, watch 1: fast.
// - sleep in subclock mode, standby 1, low 0, medium/direct/watch 1: divided mode.
// - fast/divided transitions: sleep and internal states old clock, 14 states new clock.
// - from subclock: old states at subclock, oscillator wait plus exception at new clock.
// - sleep takes two execution states and one internal state before the clock switch.
// - any transition entering or leaving subclock mode passes the watch state.
// - a clock-stop bit written 0 stops that peripheral's clock.
// - a gated peripheral is frozen as in whole-chip standby.
// - a clock-stop bit written 1 restores the clock and releases standby.
// - both clock-stop registers reset to all ones.
// - gate one holds timers A, C, F, G, converter and three serial units.
// - gate two holds lcd, pwm, watchdog and event counter.
// - a gated peripheral's pending interrupt request stays asserted.
// - after the direct transition, direct-transfer exception handling begins.
// - with direct-transfer interrupt disabled, sleep enters sleep or watch mode instead.
`default_nettype none
module pmtg_ctrl #(
    parameter int MED_DIV = 8,
    parameter int SUB_DIV = 16,
    parameter int OSC_WAIT_UNIT = 8192
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_req,
    input wire logic cpu_int_mask,
    input wire logic wake_req,
    input wire logic [11:0] periph_irq_in,
    output logic [11:0] periph_irq_out,
    output logic [11:0] periph_clk_en,
    output logic [11:0] periph_freeze,
    output logic [1:0] run_mode,
    output logic cpu_hold,
    output logic dt_exc_req,
    output logic irq
);
    localparam int CW = 32;

    logic [7:0] sys_ctrl_one;
    logic [7:0] sys_ctrl_two;
    logic [7:0] timer_a_mode;
    logic [7:0] gate_one;
    logic [7:0] gate_two;
    logic [7:0] int_enable_two;
    logic [pmtg_pkg::EVT_WIDTH-1:0] evt_status;
    logic [pmtg_pkg::EVT_WIDTH-1:0] evt_enable;
    pmtg_pkg::pmtg_state_e state;
    pmtg_pkg::pmtg_mode_e cur_mode;
    pmtg_pkg::pmtg_mode_e tgt_mode;
    pmtg_pkg::pmtg_mode_e clk_mode;
    logic [CW-1:0] cyc_cnt;
    logic [CW-1:0] st_cnt;
    logic [CW-1:0] st_limit;
    logic st_tick;
    logic wr_en;
    logic rd_en;
    logic [pmtg_pkg::EVT_WIDTH-1:0] evt_set;
    logic standby_sel;
    logic low_speed_sel;
    logic medium_sel;
    logic direct_en;
    logic watch_sel;
    logic direct_ok;
    logic dir_hit;
    logic [11:0] gate_all;
    pmtg_pkg::pmtg_mode_e dir_tgt;

    function automatic logic [CW-1:0] div_of(input pmtg_pkg::pmtg_mode_e m);
        case (m)
            pmtg_pkg::PMTG_MODE_MED: div_of = CW'(MED_DIV);
            pmtg_pkg::PMTG_MODE_SUB: div_of = CW'(SUB_DIV);
            default: div_of = CW'(1);
        endcase
    endfunction

    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
        is_addr = (a == b);
    endfunction

    assign standby_sel = sys_ctrl_one[pmtg_pkg::SC1_STANDBY_SELECT];
    assign low_speed_sel = sys_ctrl_one[pmtg_pkg::SC1_LOW_SPEED_SELECT];
    assign medium_sel = sys_ctrl_two[pmtg_pkg::SC2_MEDIUM_SPEED_SELECT];
    assign direct_en = sys_ctrl_two[pmtg_pkg::SC2_DIRECT_TRANSFER_ENABLE];
    assign watch_sel = timer_a_mode[pmtg_pkg::TMA_WATCH_ENTRY_SELECT];
    assign gate_all = {gate_two[3:0], gate_one};
    // a masked core cannot take the direct-transfer exception, so it halts instead
    assign direct_ok = direct_en & int_enable_two[pmtg_pkg::IE2_DIRECT_TRANSFER] & ~cpu_int_mask;

    always_comb begin
        dir_hit = 1'b0;
        dir_tgt = cur_mode;
        case (cur_mode)
            pmtg_pkg::PMTG_MODE_FAST: begin
                if (!standby_sel && !low_speed_sel && medium_sel) begin
                    dir_hit = 1'b1;
                    dir_tgt = pmtg_pkg::PMTG_MODE_MED;
                end else if (standby_sel && low_speed_sel && watch_sel) begin
                    dir_hit = 1'b1;
                    dir_tgt = pmtg_pkg::PMTG_MODE_SUB;
                end
            end
            pmtg_pkg::PMTG_MODE_MED: begin
                if (!standby_sel && !low_speed_sel && !medium_sel) begin
                    dir_hit = 1'b1;
                    dir_tgt = pmtg_pkg::PMTG_MODE_FAST;
                end else if (standby_sel && low_speed_sel && watch_sel) begin
                    dir_hit = 1'b1;
                    dir_tgt = pmtg_pkg::PMTG_MODE_SUB;
                end
            end
            pmtg_pkg::PMTG_MODE_SUB: begin
                if (standby_sel && !low_speed_sel && watch_sel) begin
                    dir_hit = 1'b1;
                    dir_tgt = medium_sel ? pmtg_pkg::PMTG_MODE_MED : pmtg_pkg::PMTG_MODE_FAST;
                end
            end
            default: begin
                dir_hit = 1'b0;
            end
        endcase
    end

    // per-state limit in states of the clock that currently paces the sequence
    always_comb begin
        case (state)
            pmtg_pkg::PMTG_ST_SLEEP_EXEC: st_limit = CW'(pmtg_pkg::SLEEP_EXEC_STATES);
            pmtg_pkg::PMTG_ST_INT_PROC: st_limit = CW'(pmtg_pkg::INT_PROC_STATES);
            pmtg_pkg::PMTG_ST_WATCH: st_limit = CW'(pmtg_pkg::WATCH_PASS_STATES);
            pmtg_pkg::PMTG_ST_OSC_WAIT: begin
                st_limit = CW'(OSC_WAIT_UNIT) >> sys_ctrl_one[pmtg_pkg::SC1_OSC_WAIT_HI:pmtg_pkg::SC1_OSC_WAIT_LO];
            end
            pmtg_pkg::PMTG_ST_EXC: st_limit = CW'(pmtg_pkg::EXC_STATES);
            default: st_limit = CW'(1);
        endcase
    end

    assign st_tick = (cyc_cnt == div_of(clk_mode) - CW'(1));
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_en = psel & penable & ~pready & ~pwrite;

    // apb: ready one cycle into the access phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && penable && !pready) begin
                case (paddr)
                    pmtg_pkg::ADDR_SYS_CTRL_ONE: prdata <= {24'h00_0000, sys_ctrl_one};
                    pmtg_pkg::ADDR_SYS_CTRL_TWO: prdata <= {24'h00_0000, sys_ctrl_two};
                    pmtg_pkg::ADDR_TIMER_A_MODE: prdata <= {24'h00_0000, timer_a_mode};
                    pmtg_pkg::ADDR_CLK_GATE_ONE: prdata <= {24'h00_0000, gate_one};
                    pmtg_pkg::ADDR_CLK_GATE_TWO: prdata <= {24'h00_0000, gate_two};
                    pmtg_pkg::ADDR_INT_ENABLE_TWO: prdata <= {24'h00_0000, int_enable_two};
                    pmtg_pkg::ADDR_EVT_STATUS: prdata <= {29'h0000_0000, evt_status};
                    pmtg_pkg::ADDR_EVT_CLEAR: prdata <= 32'h0000_0000;
                    pmtg_pkg::ADDR_EVT_ENABLE: prdata <= {29'h0000_0000, evt_enable};
                    pmtg_pkg::ADDR_MODE_STATUS: prdata <= {25'h000_0000, state, cur_mode, cpu_hold, 1'b0};
                    default: pslverr <= 1'b1;
                endcase
            end
            // write cycles must not leak register contents onto the read bus
            if (!rd_en) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sys_ctrl_one <= pmtg_pkg::RST_CTRL;
            sys_ctrl_two <= pmtg_pkg::RST_CTRL;
            timer_a_mode <= pmtg_pkg::RST_CTRL;
            int_enable_two <= pmtg_pkg::RST_CTRL;
            evt_enable <= '0;
        end else if (wr_en) begin
            if (is_addr(paddr, pmtg_pkg::ADDR_SYS_CTRL_ONE)) sys_ctrl_one <= pwdata[7:0];
            if (is_addr(paddr, pmtg_pkg::ADDR_SYS_CTRL_TWO)) sys_ctrl_two <= pwdata[7:0];
            if (is_addr(paddr, pmtg_pkg::ADDR_TIMER_A_MODE)) timer_a_mode <= pwdata[7:0];
            if (is_addr(paddr, pmtg_pkg::ADDR_INT_ENABLE_TWO)) int_enable_two <= pwdata[7:0];
            if (is_addr(paddr, pmtg_pkg::ADDR_EVT_ENABLE)) evt_enable <= pwdata[pmtg_pkg::EVT_WIDTH-1:0];
        end
    end

    // bit order: gate_one = {s31, s32, s1, conv, g, f, c, a}; gate_two[3:0] = {event, wdt, pwm, lcd}
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_one <= pmtg_pkg::RST_CLK_GATE;
            gate_two <= pmtg_pkg::RST_CLK_GATE;
        end else if (wr_en) begin
            if (is_addr(paddr, pmtg_pkg::ADDR_CLK_GATE_ONE)) gate_one <= pwdata[7:0];
            if (is_addr(paddr, pmtg_pkg::ADDR_CLK_GATE_TWO)) gate_two <= pwdata[7:0];
        end
    end

    // frozen requests stay up; software must mask first or the core loops on them
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            periph_clk_en <= {pmtg_pkg::RST_CLK_GATE[3:0], pmtg_pkg::RST_CLK_GATE};
            periph_freeze <= '0;
            periph_irq_out <= '0;
        end else begin
            periph_clk_en <= gate_all;
            periph_freeze <= ~gate_all;
            for (int i = 0; i < $bits(gate_all); i++) begin
                if (gate_all[i]) begin
                    periph_irq_out[i] <= periph_irq_in[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= pmtg_pkg::PMTG_ST_RUN;
            cur_mode <= pmtg_pkg::PMTG_MODE_FAST;
            tgt_mode <= pmtg_pkg::PMTG_MODE_FAST;
            clk_mode <= pmtg_pkg::PMTG_MODE_FAST;
            cyc_cnt <= '0;
            st_cnt <= '0;
        end else begin
            cyc_cnt <= st_tick ? '0 : cyc_cnt + CW'(1);
            case (state)
                pmtg_pkg::PMTG_ST_RUN: begin
                    cyc_cnt <= '0;
                    st_cnt <= '0;
                    if (sleep_req) begin
                        if (direct_ok && dir_hit) begin
                            state <= pmtg_pkg::PMTG_ST_SLEEP_EXEC;
                            tgt_mode <= dir_tgt;
                        end else begin
                            state <= pmtg_pkg::PMTG_ST_HALT;
                        end
                    end
                end
                pmtg_pkg::PMTG_ST_HALT: begin
                    if (wake_req) begin
                        state <= pmtg_pkg::PMTG_ST_RUN;
                    end
                end
                pmtg_pkg::PMTG_ST_SLEEP_EXEC, pmtg_pkg::PMTG_ST_INT_PROC, pmtg_pkg::PMTG_ST_WATCH,
                pmtg_pkg::PMTG_ST_OSC_WAIT, pmtg_pkg::PMTG_ST_EXC: begin
                    if (st_tick) begin
                        if (st_cnt + CW'(1) >= st_limit) begin
                            st_cnt <= '0;
                            case (state)
                                pmtg_pkg::PMTG_ST_SLEEP_EXEC: state <= pmtg_pkg::PMTG_ST_INT_PROC;
                                pmtg_pkg::PMTG_ST_INT_PROC: begin
                                    // switch to the new clock only after the 2+1 old-clock states
                                    clk_mode <= tgt_mode;
                                    if (cur_mode == pmtg_pkg::PMTG_MODE_SUB
                                        || tgt_mode == pmtg_pkg::PMTG_MODE_SUB) begin
                                        state <= pmtg_pkg::PMTG_ST_WATCH;
                                    end else begin
                                        state <= pmtg_pkg::PMTG_ST_EXC;
                                    end
                                end
                                pmtg_pkg::PMTG_ST_WATCH: begin
                                    if (cur_mode == pmtg_pkg::PMTG_MODE_SUB) begin
                                        state <= pmtg_pkg::PMTG_ST_OSC_WAIT;
                                    end else begin
                                        state <= pmtg_pkg::PMTG_ST_EXC;
                                    end
                                end
                                pmtg_pkg::PMTG_ST_OSC_WAIT: state <= pmtg_pkg::PMTG_ST_EXC;
                                default: begin
                                    state <= pmtg_pkg::PMTG_ST_RUN;
                                    cur_mode <= tgt_mode;
                                end
                            endcase
                        end else begin
                            st_cnt <= st_cnt + CW'(1);
                        end
                    end
                end
                default: state <= pmtg_pkg::PMTG_ST_RUN;
            endcase
        end
    end

    always_comb begin
        evt_set = '0;
        evt_set[pmtg_pkg::EVT_TRANSITION_DONE] = (state == pmtg_pkg::PMTG_ST_EXC) && st_tick
            && (st_cnt + CW'(1) >= st_limit);
        evt_set[pmtg_pkg::EVT_SLEEP_ENTERED] = (state == pmtg_pkg::PMTG_ST_RUN) && sleep_req
            && !(direct_ok && dir_hit) && !standby_sel;
        evt_set[pmtg_pkg::EVT_WATCH_ENTERED] = (state == pmtg_pkg::PMTG_ST_RUN) && sleep_req
            && !(direct_ok && dir_hit) && standby_sel;
    end

    // set beats a same-cycle clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            evt_status <= '0;
        end else if (wr_en && is_addr(paddr, pmtg_pkg::ADDR_EVT_CLEAR)) begin
            evt_status <= (evt_status & ~pwdata[pmtg_pkg::EVT_WIDTH-1:0]) | evt_set;
        end else begin
            evt_status <= evt_status | evt_set;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
            run_mode <= pmtg_pkg::PMTG_MODE_FAST;
            cpu_hold <= 1'b0;
            dt_exc_req <= 1'b0;
        end else begin
            irq <= |(evt_status & evt_enable);
            run_mode <= cur_mode;
            cpu_hold <= (state != pmtg_pkg::PMTG_ST_RUN) && (state != pmtg_pkg::PMTG_ST_EXC);
            dt_exc_req <= (state == pmtg_pkg::PMTG_ST_EXC);
        end
    end

    AST_FAST_TO_MED: assert property (@(posedge core_clk) disable iff (rst)
        (state == pmtg_pkg::PMTG_ST_RUN && sleep_req && direct_ok && cur_mode == pmtg_pkg::PMTG_MODE_FAST
         && !standby_sel && !low_speed_sel && medium_sel)
        |=> state == pmtg_pkg::PMTG_ST_SLEEP_EXEC && tgt_mode == pmtg_pkg::PMTG_MODE_MED)
        else $error("fast to divided not started");
    AST_MED_TO_FAST: assert property (@(posedge core_clk) disable iff (rst)
        (state == pmtg_pkg::PMTG_ST_RUN && sleep_req && direct_ok && cur_mode == pmtg_pkg::PMTG_MODE_MED
         && !standby_sel && !low_speed_sel && !medium_sel)
        |=> tgt_mode == pmtg_pkg::PMTG_MODE_FAST)
        else $error("divided to fast not started");
    AST_SUB_TO_FAST: assert property (@(posedge core_clk) disable iff (rst)
        (state == pmtg_pkg::PMTG_ST_RUN && sleep_req && direct_ok && cur_mode == pmtg_pkg::PMTG_MODE_SUB
         && standby_sel && !low_speed_sel && !medium_sel && watch_sel)
        |=> tgt_mode == pmtg_pkg::PMTG_MODE_FAST && state == pmtg_pkg::PMTG_ST_SLEEP_EXEC)
        else $error("subclock to fast not started");
    AST_SUB_TO_MED: assert property (@(posedge core_clk) disable iff (rst)
        (state == pmtg_pkg::PMTG_ST_RUN && sleep_req && direct_ok && cur_mode == pmtg_pkg::PMTG_MODE_SUB
         && standby_sel && !low_speed_sel && medium_sel && watch_sel)
        |=> tgt_mode == pmtg_pkg::PMTG_MODE_MED)
        else $error("subclock to divided not started");
    AST_EXC_LEN: assert property (@(posedge core_clk) disable iff (rst)
        (state == pmtg_pkg::PMTG_ST_RUN && $past(state) == pmtg_pkg::PMTG_ST_EXC)
        |-> $past(st_cnt) == CW'(pmtg_pkg::EXC_STATES - 1))
        else $error("exception handling length wrong");
    AST_SLEEP_LEN: assert property (@(posedge core_clk) disable iff (rst)
        (state == pmtg_pkg::PMTG_ST_INT_PROC && $past(state) == pmtg_pkg::PMTG_ST_SLEEP_EXEC)
        |-> $past(st_cnt) == CW'(pmtg_pkg::SLEEP_EXEC_STATES - 1) && clk_mode == cur_mode)
        else $error("sleep execution length wrong");
    AST_VIA_WATCH: assert property (@(posedge core_clk) disable iff (rst)
        ($past(state) == pmtg_pkg::PMTG_ST_INT_PROC && state != pmtg_pkg::PMTG_ST_INT_PROC
         && (cur_mode == pmtg_pkg::PMTG_MODE_SUB || tgt_mode == pmtg_pkg::PMTG_MODE_SUB))
        |-> state == pmtg_pkg::PMTG_ST_WATCH)
        else $error("subclock transition skipped watch");
    AST_GATE_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        (wr_en && paddr == pmtg_pkg::ADDR_CLK_GATE_ONE) ##2 !(wr_en && paddr == pmtg_pkg::ADDR_CLK_GATE_ONE)
        |-> periph_clk_en[7:0] == $past(pwdata[7:0], 2) && periph_freeze[7:0] == ~$past(pwdata[7:0], 2))
        else $error("clock gate not applied");
    AST_GATE_RESET: assert property (@(posedge core_clk)
        $fell(rst) |-> gate_one == pmtg_pkg::RST_CLK_GATE && gate_two == pmtg_pkg::RST_CLK_GATE)
        else $error("clock gates not all ones after reset");
    AST_IRQ_HELD: assert property (@(posedge core_clk) disable iff (rst)
        ((periph_irq_out ^ $past(periph_irq_out)) & ~$past(gate_all)) == 12'h000)
        else $error("gated request changed");
    AST_DT_EXC: assert property (@(posedge core_clk) disable iff (rst)
        (state == pmtg_pkg::PMTG_ST_EXC && $past(state) != pmtg_pkg::PMTG_ST_EXC) |=> dt_exc_req)
        else $error("direct exception not requested");
    AST_NO_DIRECT: assert property (@(posedge core_clk) disable iff (rst)
        (state == pmtg_pkg::PMTG_ST_RUN && sleep_req && !direct_ok) |=> state == pmtg_pkg::PMTG_ST_HALT)
        else $error("sleep did not halt");

    COV_FAST_MED: cover property (@(posedge core_clk) disable iff (rst)
        state == pmtg_pkg::PMTG_ST_EXC && tgt_mode == pmtg_pkg::PMTG_MODE_MED);
    COV_SUB_WAIT: cover property (@(posedge core_clk) disable iff (rst)
        state == pmtg_pkg::PMTG_ST_OSC_WAIT ##1 state == pmtg_pkg::PMTG_ST_EXC);
    COV_HALT_WAKE: cover property (@(posedge core_clk) disable iff (rst)
        state == pmtg_pkg::PMTG_ST_HALT ##1 state == pmtg_pkg::PMTG_ST_RUN);
    COV_GATED: cover property (@(posedge core_clk) disable iff (rst) periph_freeze != 12'h000);
endmodule
`default_nettype wire

//--- pmtg_core_model.sv
`default_nettype none
module pmtg_core_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cpu_hold,
    input wire logic sleep_cmd,
    input wire logic wake_cmd,
    input wire logic mask_cmd,
    output logic sleep_req,
    output logic wake_req,
    output logic cpu_int_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    // a stalled core cannot issue another sleep
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sleep_req <= 1'b0;
            wake_req <= 1'b0;
            cpu_int_mask <= 1'b0;
        end else begin
            sleep_req <= sleep_cmd && !cpu_hold;
            wake_req <= wake_cmd;
            cpu_int_mask <= mask_cmd;
        end
    end
endmodule
`default_nettype wire

//--- power_mode_transition_and_gating_tb.sv
`default_nettype none
module power_mode_transition_and_gating_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MED = 2;
    localparam int SUB = 4;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, sleep_req, cpu_int_mask, wake_req, er;
    logic sleep_cmd, wake_cmd, mask_cmd, cpu_hold, dt_exc_req, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] irq_in, irq_out, clk_en, freeze;
    logic [1:0] run_mode;
    int err_count, comparisons, exc_cnt;
    pmtg_ctrl #(.MED_DIV(MED), .SUB_DIV(SUB), .OSC_WAIT_UNIT(16)) u_dut (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sleep_req(sleep_req), .cpu_int_mask(cpu_int_mask),
        .wake_req(wake_req), .periph_irq_in(irq_in), .periph_irq_out(irq_out), .periph_clk_en(clk_en),
        .periph_freeze(freeze), .run_mode(run_mode), .cpu_hold(cpu_hold), .dt_exc_req(dt_exc_req), .irq(irq));
    pmtg_core_model u_core (.core_clk(core_clk), .rst(rst), .cpu_hold(cpu_hold), .sleep_cmd(sleep_cmd),
        .wake_cmd(wake_cmd), .mask_cmd(mask_cmd), .sleep_req(sleep_req), .wake_req(wake_req),
        .cpu_int_mask(cpu_int_mask));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (dt_exc_req === 1'b1) exc_cnt++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("errors=%0d comparisons=%0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // answer read at the rising edge that samples it; only the watchdog ends a stuck wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // sleep from the core, then wait for the mode to settle and count exception cycles
    task automatic trans(input logic [7:0] s1, input logic [7:0] s2, input logic [1:0] m, input int ex);
        int n;
        apb(1'b1, pmtg_pkg::ADDR_SYS_CTRL_ONE, {24'h0, s1});
        apb(1'b1, pmtg_pkg::ADDR_SYS_CTRL_TWO, {24'h0, s2});
        exc_cnt = 0;
        sleep_cmd <= 1'b1;
        @(posedge core_clk);
        sleep_cmd <= 1'b0;
        for (n = 0; n < 3000 && run_mode !== m; n++) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        chk(32'(run_mode), 32'(m));
        chk(32'(exc_cnt), 32'(ex));
    endtask
    initial begin
        {rst, psel, penable, pwrite, sleep_cmd, wake_cmd, mask_cmd, paddr, pwdata, irq_in} = '1;
        {psel, penable, pwrite, sleep_cmd, wake_cmd, mask_cmd, paddr, pwdata, irq_in} = '0;
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        apb(1'b0, pmtg_pkg::ADDR_CLK_GATE_ONE, 32'h0);
        chk(rd, 32'hff);
        apb(1'b0, pmtg_pkg::ADDR_CLK_GATE_TWO, 32'h0);
        chk(rd, 32'hff);
        chk(32'(clk_en), 32'hfff);
        apb(1'b0, 8'h30, 32'h0);
        chk({31'h0, er}, 32'h1);
        mask_cmd <= 1'b1;
        irq_in <= 12'h001;
        apb(1'b1, pmtg_pkg::ADDR_CLK_GATE_ONE, 32'hfe);
        repeat (2) @(posedge core_clk);
        irq_in <= 12'h000;
        repeat (3) @(negedge core_clk);
        chk(32'(clk_en), 32'hffe);
        chk(32'(freeze), 32'h001);
        chk(32'(irq_out), 32'h001);
        apb(1'b1, pmtg_pkg::ADDR_CLK_GATE_ONE, 32'hff);
        apb(1'b1, pmtg_pkg::ADDR_CLK_GATE_TWO, 32'h07);
        repeat (3) @(negedge core_clk);
        chk(32'(clk_en), 32'h7ff);
        chk(32'(irq_out), 32'h000);
        mask_cmd <= 1'b0;
        apb(1'b1, pmtg_pkg::ADDR_TIMER_A_MODE, 32'h08);
        apb(1'b1, pmtg_pkg::ADDR_INT_ENABLE_TWO, 32'h01);
        trans(8'h00, 8'h0c, 2'b01, 14 * MED);
        trans(8'h00, 8'h08, 2'b00, 14);
        trans(8'h88, 8'h08, 2'b10, 14 * SUB);
        trans(8'h80, 8'h0c, 2'b01, 14 * MED);
        trans(8'h88, 8'h08, 2'b10, 14 * SUB);
        trans(8'h80, 8'h08, 2'b00, 14);
        apb(1'b1, pmtg_pkg::ADDR_INT_ENABLE_TWO, 32'h0);
        trans(8'h00, 8'h08, 2'b00, 0);
        chk(32'(cpu_hold), 32'h1);
        @(posedge core_clk) wake_cmd <= 1'b1;
        @(posedge core_clk) wake_cmd <= 1'b0;
        repeat (4) @(negedge core_clk);
        chk(32'(cpu_hold), 32'h0);
        apb(1'b0, pmtg_pkg::ADDR_EVT_STATUS, 32'h0);
        chk(rd & 32'h3, 32'h3);
        chk(32'(irq), 32'h0);
        apb(1'b1, pmtg_pkg::ADDR_EVT_ENABLE, 32'h02);
        repeat (2) @(negedge core_clk);
        chk(32'(irq), 32'h1);
        apb(1'b1, pmtg_pkg::ADDR_EVT_CLEAR, 32'h02);
        repeat (2) @(negedge core_clk);
        chk(32'(irq), 32'h0);
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        end_of_test();
    end
endmodule
`default_nettype wire
